//--- include/adp_pkg.sv
// adp_pkg: register map, field positions, opcodes and states of the datapath.
// assumes a 32-bit AXI4-Lite master on the single core clock.
package adp_pkg;
    localparam int ADDR_W = 8;
    localparam int ACC_W = 40;
    localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] A_OPA = 8'h04;
    localparam logic [ADDR_W-1:0] A_OPB = 8'h08;
    localparam logic [ADDR_W-1:0] A_OPH = 8'h0C;
    localparam logic [ADDR_W-1:0] A_MEMOP = 8'h10;
    localparam logic [ADDR_W-1:0] A_CORE = 8'h14;
    localparam logic [ADDR_W-1:0] A_STAT = 8'h18;
    localparam logic [ADDR_W-1:0] A_WREG0 = 8'h1C;
    localparam logic [ADDR_W-1:0] A_WREG1 = 8'h20;
    localparam logic [ADDR_W-1:0] A_ACC_A_L = 8'h24;
    localparam logic [ADDR_W-1:0] A_ACC_A_H = 8'h28;
    localparam logic [ADDR_W-1:0] A_ACC_B_L = 8'h2C;
    localparam logic [ADDR_W-1:0] A_ACC_B_H = 8'h30;
    localparam logic [ADDR_W-1:0] A_MEMWB = 8'h34;
    // control word fields
    localparam int C_BYTE = 5;
    localparam int C_ACC_SEL = 6;
    localparam int C_WB = 7;
    localparam int C_SRC = 8;
    localparam int C_DST = 9;
    // status bits
    localparam int S_C = 0;
    localparam int S_Z = 1;
    localparam int S_N = 2;
    localparam int S_RANGE = 3;
    localparam int S_HALF = 4;
    localparam int S_BUSY = 8;
    // core control bits
    localparam int K_FRAC = 0;
    localparam int K_UNS = 1;
    localparam int K_ROUND = 2;
    localparam int K_CLAMP_A = 3;
    localparam int K_CLAMP_B = 4;
    localparam int K_CLAMP_M = 5;
    localparam int K_CLAMP_MODE = 6;
    localparam logic [6:0] CORE_RST = 7'h00;
    localparam logic [4:0] DIV_CYC = 5'h10;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    localparam logic [39:0] MAX40 = 40'h7F_FFFF_FFFF;
    localparam logic [39:0] MIN40 = 40'h80_0000_0000;
    localparam logic [39:0] MAX32 = 40'h00_7FFF_FFFF;
    localparam logic [39:0] MIN32 = 40'hFF_8000_0000;
    localparam logic [15:0] ROUND_TIE = 16'h8000;
    localparam logic [15:0] MEM_MAX = 16'h7FFF;
    localparam logic [15:0] MEM_MIN = 16'h8000;
    typedef enum logic [4:0] {
        OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_SL, OP_LSR, OP_ASR,
        OP_MUL_SS, OP_MUL_UU, OP_MUL_SU, OP_MUL_UNS_SGN, OP_MUL_LS, OP_MUL_LU, OP_MUL_BB,
        OP_DIV_S32, OP_DIV_U32, OP_DIV_S16, OP_DIV_U16,
        OP_MULT_ACC, OP_MULT_SUB, OP_MULTIPLY, OP_SQ_DIFF, OP_SQ_DIFF_ACC,
        OP_ACC_ADD, OP_ACC_SUB, OP_ACC_NEG, OP_ACC_SHIFT, OP_ACC_CLR
    } adp_op_t;
    typedef enum logic {ST_IDLE, ST_DIV} adp_st_t;
endpackage

//--- rtl/adp_datapath.sv
// adp_datapath: integer alu, multiplier, iterative divider and dsp engine.
// assumes operands are staged by the decoder over AXI4-Lite before a go.
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Summary of operation
// - sixteen-bit alu does add, subtract, shifts and logic in two's complement.
// - alu ops update zero and negative; add/subtract also carry, range and half-carry; shifts also carry.
// - subtraction carry and half carry report borrow and digit borrow.
// - byte or word width per instruction; flags follow chosen width.
// - operands from register or memory; result to register or memory.
// - integer multiply uses 17x17 multiplier with sign or zero extension.
// - signed, unsigned, mixed, literal and byte multiply modes.
// - signed and unsigned divide, 32- or 16-bit dividend, 16-bit divisor.
// - divide quotient goes to work_reg_zero, remainder to work_reg_one.
// - any divisor register; dividend pair with high word in odd register.
// - divider takes one cycle per divisor bit for both forms.
// - dsp engine has multiplier, barrel shifter, 40-bit adder, round, clamp.
// - dsp and integer operations never overlap; squared difference uses both.
// - accumulator add, subtract, negate use only the two accumulators.
// - core control selects fractional and unsigned dsp multiply.
// - rounding_style_sel picks conventional or convergent rounding.
// - separate clamp enables per accumulator and memory write; mode select.
// - mult_accumulate_op adds product, may write other accumulator out.
// - mult_subtract_op subtracts product, may write other accumulator out.
module adp_datapath (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [adp_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [adp_pkg::ADDR_W-1:0] s_axi_araddr_i,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o
);
    import adp_pkg::*;

    logic aw_full_r, w_full_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [ADDR_W-1:0] waddr_r;
    logic [31:0] wdata_r, rdata_r, rd_val;
    logic [3:0] wstrb_r;
    logic [9:0] ctrl_r;
    logic [15:0] opa_r, opb_r, oph_r, memop_r, wreg0_r, wreg1_r, memwb_r;
    logic [6:0] core_r;
    logic [4:0] flags_r, fl_nxt;
    logic [ACC_W-1:0] acc_a_r, acc_b_r;
    adp_st_t st_r;
    logic [4:0] cnt_r;
    logic [15:0] rem_r, dq_r, dvs_r;
    logic qneg_r, rneg_r;

    // bus handshake
    wire aw_ok = s_axi_awvalid_i & awready_r;
    wire w_ok = s_axi_wvalid_i & wready_r;
    wire wr_do = aw_full_r & w_full_r & ~bvalid_r;
    wire aw_full_nxt = (aw_full_r | aw_ok) & ~wr_do;
    wire w_full_nxt = (w_full_r | w_ok) & ~wr_do;
    wire ar_ok = s_axi_arvalid_i & arready_r;
    wire w_map = (waddr_r[1:0] == 2'h0) && (waddr_r <= A_MEMWB);
    wire r_map = (s_axi_araddr_i[1:0] == 2'h0) && (s_axi_araddr_i <= A_MEMWB);
    wire [31:0] bm = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    wire [31:0] cw = wdata_r;
    wire busy = (st_r == ST_DIV);
    wire go = wr_do && (waddr_r == A_CTRL) && !busy;
    wire byt = cw[C_BYTE];
    wire tgt_b = cw[C_ACC_SEL];
    adp_op_t op;
    assign op = adp_op_t'(cw[4:0]);

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OK;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            awready_r <= ~aw_full_nxt;
            wready_r <= ~w_full_nxt;
            if (wr_do) begin
                bvalid_r <= 1'b1;
                bresp_r <= w_map ? RESP_OK : RESP_ERR;
            end else if (bvalid_r && s_axi_bready_i) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (aw_ok) begin
            waddr_r <= s_axi_awaddr_i;
        end
        if (w_ok) begin
            wdata_r <= s_axi_wdata_i;
            wstrb_r <= s_axi_wstrb_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= RESP_OK;
        end else if (ar_ok) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_val;
            rresp_r <= r_map ? RESP_OK : RESP_ERR;
        end else if (rvalid_r && s_axi_rready_i) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end
    end

    always_comb begin
        rd_val = 32'h0;
        unique case (s_axi_araddr_i)
            A_CTRL: rd_val = {22'h0, ctrl_r};
            A_OPA: rd_val = {16'h0, opa_r};
            A_OPB: rd_val = {16'h0, opb_r};
            A_OPH: rd_val = {16'h0, oph_r};
            A_MEMOP: rd_val = {16'h0, memop_r};
            A_CORE: rd_val = {25'h0, core_r};
            A_STAT: rd_val = {23'h0, busy, 3'h0, flags_r};
            A_WREG0: rd_val = {16'h0, wreg0_r};
            A_WREG1: rd_val = {16'h0, wreg1_r};
            A_ACC_A_L: rd_val = acc_a_r[31:0];
            A_ACC_A_H: rd_val = {24'h0, acc_a_r[39:32]};
            A_ACC_B_L: rd_val = acc_b_r[31:0];
            A_ACC_B_H: rd_val = {24'h0, acc_b_r[39:32]};
            A_MEMWB: rd_val = {16'h0, memwb_r};
            default: rd_val = 32'h0;
        endcase
    end

    // software-written operand and control registers
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ctrl_r <= 10'h0;
            opa_r <= 16'h0;
            opb_r <= 16'h0;
            oph_r <= 16'h0;
            memop_r <= 16'h0;
            core_r <= CORE_RST;
        end else if (wr_do) begin
            unique case (waddr_r)
                A_CTRL: ctrl_r <= go ? cw[9:0] : ctrl_r;
                A_OPA: opa_r <= (opa_r & ~bm[15:0]) | (wdata_r[15:0] & bm[15:0]);
                A_OPB: opb_r <= (opb_r & ~bm[15:0]) | (wdata_r[15:0] & bm[15:0]);
                A_OPH: oph_r <= (oph_r & ~bm[15:0]) | (wdata_r[15:0] & bm[15:0]);
                A_MEMOP: memop_r <= (memop_r & ~bm[15:0]) | (wdata_r[15:0] & bm[15:0]);
                A_CORE: core_r <= (core_r & ~bm[6:0]) | (wdata_r[6:0] & bm[6:0]);
                default: ;
            endcase
        end
    end

    // integer alu
    wire [15:0] b_op = cw[C_SRC] ? memop_r : opb_r;
    wire is_add = (op == OP_ADD);
    wire is_sub = (op == OP_SUB);
    wire is_as = is_add | is_sub;
    wire is_lg = (op == OP_AND) | (op == OP_IOR) | (op == OP_XOR);
    wire is_sh = (op == OP_SL) | (op == OP_LSR) | (op == OP_ASR);
    wire is_alu = is_as | is_lg | is_sh;
    wire [15:0] bx = is_sub ? ~b_op : b_op;
    wire [16:0] sum = {1'b0, opa_r} + {1'b0, bx} + {16'h0, is_sub};
    wire [8:0] sum_b = {1'b0, opa_r[7:0]} + {1'b0, bx[7:0]} + {8'h0, is_sub};
    wire [4:0] nib = {1'b0, opa_r[3:0]} + {1'b0, bx[3:0]} + {4'h0, is_sub};
    logic [15:0] alu;
    logic c_sh;
    always_comb begin
        alu = 16'h0;
        c_sh = 1'b0;
        unique case (op)
            OP_ADD, OP_SUB: alu = sum[15:0];
            OP_AND: alu = opa_r & b_op;
            OP_IOR: alu = opa_r | b_op;
            OP_XOR: alu = opa_r ^ b_op;
            OP_SL: begin
                alu = {opa_r[14:0], 1'b0};
                c_sh = byt ? opa_r[7] : opa_r[15];
            end
            OP_LSR: begin
                alu = byt ? {9'h0, opa_r[7:1]} : {1'b0, opa_r[15:1]};
                c_sh = opa_r[0];
            end
            OP_ASR: begin
                alu = byt ? {8'h0, opa_r[7], opa_r[7:1]} : {opa_r[15], opa_r[15:1]};
                c_sh = opa_r[0];
            end
            default: ;
        endcase
    end
    wire [15:0] res_w = byt ? {opa_r[15:8], alu[7:0]} : alu;
    wire a_m = byt ? opa_r[7] : opa_r[15];
    wire b_m = byt ? bx[7] : bx[15];
    wire r_m = byt ? alu[7] : alu[15];
    // subtract adds the complement: carry set means no borrow
    wire cy = byt ? sum_b[8] : sum[16];
    wire hc = byt ? nib[4] : sum_b[8];
    always_comb begin
        fl_nxt = flags_r;
        fl_nxt[S_Z] = byt ? ~|alu[7:0] : ~|alu;
        fl_nxt[S_N] = r_m;
        if (is_as) begin
            fl_nxt[S_C] = cy;
            fl_nxt[S_HALF] = hc;
            fl_nxt[S_RANGE] = (a_m == b_m) && (r_m != a_m);
        end else if (is_sh) begin
            fl_nxt[S_C] = c_sh;
        end
    end

    // shared 17x17 multiplier
    wire is_mul = (op >= OP_MUL_SS) && (op <= OP_MUL_BB);
    wire is_sq = (op == OP_SQ_DIFF) | (op == OP_SQ_DIFF_ACC);
    wire [16:0] dif = {opa_r[15], opa_r} - {b_op[15], b_op};
    logic sa, sb;
    logic [15:0] ma16, mb16;
    always_comb begin
        sa = 1'b0;
        sb = 1'b0;
        ma16 = opa_r;
        mb16 = b_op;
        unique case (op)
            OP_MUL_SS: begin
                sa = 1'b1;
                sb = 1'b1;
            end
            OP_MUL_SU: sa = 1'b1;
            OP_MUL_UNS_SGN: sb = 1'b1;
            OP_MUL_LS: begin
                sa = 1'b1;
                mb16 = {11'h0, b_op[4:0]};
            end
            OP_MUL_LU: mb16 = {11'h0, b_op[4:0]};
            OP_MUL_BB: begin
                ma16 = {8'h0, opa_r[7:0]};
                mb16 = {8'h0, b_op[7:0]};
            end
            OP_MULT_ACC, OP_MULT_SUB, OP_MULTIPLY: begin
                sa = ~core_r[K_UNS];
                sb = ~core_r[K_UNS];
            end
            default: ;
        endcase
    end
    wire [16:0] m_a = is_sq ? dif : {sa & ma16[15], ma16};
    wire [16:0] m_b = is_sq ? dif : {sb & mb16[15], mb16};
    logic signed [33:0] prod;
    assign prod = $signed({{17{m_a[16]}}, m_a}) * $signed({{17{m_b[16]}}, m_b});
    wire [39:0] p40 = {{6{prod[33]}}, prod};
    wire [39:0] pf = core_r[K_FRAC] ? {p40[38:0], 1'b0} : p40;

    // dsp engine: 40-bit adder with clamp and rounding
    wire [ACC_W-1:0] acc_t = tgt_b ? acc_b_r : acc_a_r;
    wire [ACC_W-1:0] acc_o = tgt_b ? acc_a_r : acc_b_r;
    wire [5:0] sh = b_op[5:0];
    wire [5:0] shn = 6'h0 - sh;
    wire [39:0] shv = sh[5] ? (acc_t << shn) : 40'($signed(acc_t) >>> sh);
    wire is_dsp = (op >= OP_MULT_ACC) && (op <= OP_ACC_CLR);
    logic [39:0] da, db;
    logic dsub;
    always_comb begin
        da = 40'h0;
        db = 40'h0;
        dsub = 1'b0;
        unique case (op)
            OP_MULT_ACC, OP_SQ_DIFF_ACC: begin
                da = acc_t;
                db = pf;
            end
            OP_MULT_SUB: begin
                da = acc_t;
                db = pf;
                dsub = 1'b1;
            end
            OP_MULTIPLY, OP_SQ_DIFF: db = pf;
            OP_ACC_ADD: begin
                da = acc_t;
                db = acc_o;
            end
            OP_ACC_SUB: begin
                da = acc_t;
                db = acc_o;
                dsub = 1'b1;
            end
            OP_ACC_NEG: begin
                db = acc_t;
                dsub = 1'b1;
            end
            OP_ACC_SHIFT: da = shv;
            default: ;
        endcase
    end
    wire [40:0] dbx = dsub ? ~{db[39], db} : {db[39], db};
    wire [40:0] r41 = {da[39], da} + dbx + {40'h0, dsub};
    wire ovf40 = r41[40] ^ r41[39];
    wire big32 = ~(&r41[40:31] | ~|r41[40:31]);
    wire sat_en = tgt_b ? core_r[K_CLAMP_B] : core_r[K_CLAMP_A];
    wire [39:0] lim40 = r41[40] ? MIN40 : MAX40;
    wire [39:0] lim32 = r41[40] ? MIN32 : MAX32;
    wire [39:0] sat40 = ovf40 ? lim40 : r41[39:0];
    wire [39:0] sat32 = big32 ? lim32 : r41[39:0];
    wire [39:0] acc_nxt = !sat_en ? r41[39:0] : (core_r[K_CLAMP_MODE] ? sat40 : sat32);
    // write-back of the other accumulator, rounded to a word
    wire tie = (acc_o[15:0] == ROUND_TIE);
    wire rnd_up = core_r[K_ROUND] ? (acc_o[15] & (~tie | acc_o[16])) : acc_o[15];
    wire [23:0] r24 = acc_o[39:16] + {23'h0, rnd_up};
    wire m_big = ~(&r24[23:15] | ~|r24[23:15]);
    wire [15:0] m_lim = r24[23] ? MEM_MIN : MEM_MAX;
    wire [15:0] wbv = (core_r[K_CLAMP_M] && m_big) ? m_lim : r24[15:0];
    wire wb_ok = (op == OP_MULT_ACC) | (op == OP_MULT_SUB) | (op == OP_ACC_CLR);

    // divider
    wire is_div = (op >= OP_DIV_S32) && (op <= OP_DIV_U16);
    wire dsg = (op == OP_DIV_S32) | (op == OP_DIV_S16);
    wire d32 = (op == OP_DIV_S32) | (op == OP_DIV_U32);
    wire [31:0] dvd = d32 ? {oph_r, opa_r} : {{16{dsg & opa_r[15]}}, opa_r};
    wire neg_n = dsg & dvd[31];
    wire neg_d = dsg & b_op[15];
    wire [31:0] mag_n = neg_n ? 32'h0 - dvd : dvd;
    wire [15:0] mag_d = neg_d ? 16'h0 - b_op : b_op;
    wire [17:0] trial = {1'b0, rem_r, dq_r[15]} - {2'h0, dvs_r};
    wire ge = ~trial[17];
    wire [15:0] rem_nxt = ge ? trial[15:0] : {rem_r[14:0], dq_r[15]};
    wire [15:0] dq_nxt = {dq_r[14:0], ge};
    wire div_end = busy && (cnt_r == DIV_CYC - 5'h1);
    wire [15:0] qv = qneg_r ? 16'h0 - dq_nxt : dq_nxt;
    wire [15:0] rv = rneg_r ? 16'h0 - rem_nxt : rem_nxt;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st_r <= ST_IDLE;
            cnt_r <= 5'h0;
        end else if (go && is_div) begin
            st_r <= ST_DIV;
            cnt_r <= 5'h0;
        end else if (busy) begin
            st_r <= div_end ? ST_IDLE : ST_DIV;
            cnt_r <= cnt_r + 5'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (go && is_div) begin
            rem_r <= mag_n[31:16];
            dq_r <= mag_n[15:0];
            dvs_r <= mag_d;
            qneg_r <= neg_n ^ neg_d;
            rneg_r <= neg_n;
        end else if (busy) begin
            rem_r <= rem_nxt;
            dq_r <= dq_nxt;
        end
    end

    // results, flags and accumulators
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            flags_r <= 5'h0;
            wreg0_r <= 16'h0;
            wreg1_r <= 16'h0;
            acc_a_r <= 40'h0;
            acc_b_r <= 40'h0;
            memwb_r <= 16'h0;
        end else begin
            if (go && is_alu) begin
                flags_r <= fl_nxt;
                if (cw[C_DST]) begin
                    memwb_r <= res_w;
                end else begin
                    wreg0_r <= res_w;
                end
            end
            if (go && is_mul) begin
                wreg0_r <= prod[15:0];
                wreg1_r <= prod[31:16];
            end
            if (go && is_dsp) begin
                if (tgt_b) begin
                    acc_b_r <= acc_nxt;
                end else begin
                    acc_a_r <= acc_nxt;
                end
                if (cw[C_WB] && wb_ok) begin
                    memwb_r <= wbv;
                end
            end
            if (div_end) begin
                wreg0_r <= qv;
                wreg1_r <= rv;
            end
        end
    end

    assign s_axi_awready_o = awready_r;
    assign s_axi_wready_o = wready_r;
    assign s_axi_bvalid_o = bvalid_r;
    assign s_axi_bresp_o = bresp_r;
    assign s_axi_arready_o = arready_r;
    assign s_axi_rvalid_o = rvalid_r;
    assign s_axi_rdata_o = rdata_r;
    assign s_axi_rresp_o = rresp_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    wire alu_w = go && is_alu && !cw[C_DST];
    chk_alu_add: assert property (alu_w && is_add && !byt
        |=> wreg0_r == 16'($past(opa_r) + $past(b_op))) else $error("add result wrong");
    chk_zero_flag: assert property (alu_w && !byt
        |=> flags_r[S_Z] == (wreg0_r == 16'h0)) else $error("zero flag wrong");
    chk_sub_borrow: assert property (go && is_sub && !byt
        |=> flags_r[S_C] == ($past(opa_r) >= $past(b_op))) else $error("borrow wrong");
    chk_byte_width: assert property (alu_w && byt
        |=> wreg0_r[15:8] == $past(opa_r[15:8]) && flags_r[S_N] == wreg0_r[7])
        else $error("byte mode wrong");
    chk_mem_dest: assert property (go && is_alu && cw[C_DST]
        |=> memwb_r == $past(res_w) && $stable(wreg0_r)) else $error("memory dest wrong");
    chk_mul_signed: assert property (go && op == OP_MUL_SS
        |=> $signed({wreg1_r, wreg0_r}) == $signed($past(opa_r)) * $signed($past(b_op)))
        else $error("signed multiply wrong");
    chk_mul_uns: assert property (go && op == OP_MUL_UU
        |=> {wreg1_r, wreg0_r} == $past(opa_r) * $past(b_op)) else $error("mul wrong");
    chk_div_cycles: assert property (go && is_div
        |=> busy ##15 busy ##1 !busy) else $error("divide length wrong");
    chk_div_result: assert property (go && op == OP_DIV_U16 && b_op != 16'h0
        |-> ##17 wreg0_r == $past(opa_r, 17) / $past(b_op, 17)
        && wreg1_r == $past(opa_r, 17) % $past(b_op, 17)) else $error("divide wrong");
    chk_no_overlap: assert property (busy && wr_do && waddr_r == A_CTRL
        |=> $stable(acc_a_r) && $stable(acc_b_r) && $stable(flags_r)) else $error("overlap");
    chk_acc_neg: assert property (go && op == OP_ACC_NEG && !tgt_b
        && !core_r[K_CLAMP_A] |=> acc_a_r == 40'h0 - $past(acc_a_r))
        else $error("negate wrong");
    chk_acc_clamp: assert property (go && is_dsp && !tgt_b && core_r[K_CLAMP_A]
        && !core_r[K_CLAMP_MODE] |=> (&acc_a_r[39:31] | ~|acc_a_r[39:31]))
        else $error("clamp wrong");
    chk_mac_sum: assert property (go && op == OP_MULT_ACC && !tgt_b
        && !core_r[K_CLAMP_A] |=> acc_a_r == 40'($past(acc_a_r) + $past(pf)))
        else $error("mac wrong");
    cov_div_signed: cover property (go && op == OP_DIV_S32 ##17 !busy);
    cov_mac_wb: cover property (go && op == OP_MULT_ACC && cw[C_WB]);
    cov_byte_alu: cover property (go && is_alu && byt);
    cov_clamp_hit: cover property (go && is_dsp && sat_en && big32);
endmodule

//--- tb/adp_host.sv
// adp_host: decoder-side model issuing one register access at a time.
// assumes the bench calls go serially; a wait that runs out returns resp 3.
`timescale 1ns/1ps
module adp_host (
    input wire logic clk_i,
    output logic aw_o = 1'b0,
    output logic w_o = 1'b0,
    output logic [7:0] a_o = 8'h00,
    output logic [31:0] d_o = 32'h0,
    output logic b_o = 1'b0,
    output logic ar_o = 1'b0,
    output logic r_o = 1'b0,
    input wire logic awr_i,
    input wire logic wr_i,
    input wire logic bv_i,
    input wire logic [1:0] br_i,
    input wire logic arr_i,
    input wire logic rv_i,
    input wire logic [31:0] rd_i,
    input wire logic [1:0] rr_i
);
    task automatic go(input logic w, input logic [7:0] a, inout logic [31:0] d,
        output logic [1:0] rs);
        rs = 2'h3;
        @(posedge clk_i);
        aw_o <= w;
        w_o <= w;
        b_o <= w;
        ar_o <= !w;
        r_o <= !w;
        a_o <= a;
        d_o <= d;
        for (int i = 0; i < 64 && rs === 2'h3; i++) begin
            @(posedge clk_i);
            if (awr_i) aw_o <= 1'b0;
            if (wr_i) w_o <= 1'b0;
            if (arr_i) ar_o <= 1'b0;
            if ((w && bv_i) || (!w && rv_i)) begin
                rs = w ? br_i : rr_i;
                d = w ? d : rd_i;
                b_o <= 1'b0;
                r_o <= 1'b0;
            end
        end
    endtask
endmodule

//--- tb/tb_cpu_alu_mul_div_dsp_datapath.sv
// tb_cpu_alu_mul_div_dsp_datapath: register-level checks of alu, mul, div, dsp.
// assumes adp_host drives the register bus on the single core clock.
`timescale 1ns/1ps
module tb_cpu_alu_mul_div_dsp_datapath;
    import adp_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [7:0] s_axi_awaddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    int n_errors = 0;
    int compares = 0;
    always #50 clk_i = ~clk_i;
    adp_datapath dut_u (.clk_i, .rstn_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_awaddr_i,
        .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_wdata_i, .s_axi_wstrb_i(4'hF), .s_axi_bvalid_o,
        .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o,
        .s_axi_araddr_i(s_axi_awaddr_i), .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o,
        .s_axi_rresp_o);
    adp_host h (.clk_i, .aw_o(s_axi_awvalid_i), .w_o(s_axi_wvalid_i), .a_o(s_axi_awaddr_i),
        .d_o(s_axi_wdata_i), .b_o(s_axi_bready_i), .ar_o(s_axi_arvalid_i), .r_o(s_axi_rready_i),
        .awr_i(s_axi_awready_o), .wr_i(s_axi_wready_o), .bv_i(s_axi_bvalid_o),
        .br_i(s_axi_bresp_o), .arr_i(s_axi_arready_o), .rv_i(s_axi_rvalid_o),
        .rd_i(s_axi_rdata_o), .rr_i(s_axi_rresp_o));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic abort();
        n_errors++;
        stop_test();
    endtask
    task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er = RESP_OK);
        logic [31:0] d;
        logic [1:0] rs;
        d = e;
        h.go(w, a, d, rs);
        if (rs === 2'h3) abort();
        chk({30'h0, rs}, {30'h0, er});
        if (!w) chk(d, e);
    endtask
    task automatic op(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
        ax(1, A_OPA, a);
        ax(1, A_OPB, b);
        ax(1, A_CTRL, c);
    endtask
    task automatic t_alu();
        op(32'h7FFF, 32'h1, OP_ADD);
        ax(0, A_WREG0, 32'h8000);
        ax(0, A_STAT, 32'h1C);
        op(32'h0, 32'h1, OP_SUB);
        ax(0, A_WREG0, 32'hFFFF);
        ax(0, A_STAT, 32'h04);
        op(32'h12FF, 32'h1, 32'h20);
        ax(0, A_WREG0, 32'h1200);
        ax(0, A_STAT, 32'h13);
        ax(1, A_MEMOP, 32'h5);
        op(32'h3, 32'h0, 32'h300);
        ax(0, A_MEMWB, 32'h8);
    endtask
    task automatic t_mul();
        logic [31:0] mp[7] = '{32'h10000, 32'h7FFF0000, 32'hFFFF0000, 32'h80010000,
            32'hFFFFFFC2, 32'h1EFFC2, 32'h2FA};
        for (int i = 0; i < 7; i++) begin
            op(i < 6 ? 32'hFFFE : 32'h12FE, i < 4 ? 32'h8000 : i < 6 ? 32'h1F : 32'h3403,
                OP_MUL_SS + i);
            ax(0, A_WREG0, mp[i][15:0]);
            ax(0, A_WREG1, mp[i][31:16]);
        end
    endtask
    task automatic t_div();
        logic [31:0] q[4] = '{32'hFFFD, 32'h1000, 32'hFFFD, 32'h7FFC};
        logic [31:0] r[4] = '{32'hFFFF, 32'h5, 32'hFFFF, 32'h1};
        logic [31:0] s;
        logic [1:0] rs;
        int n;
        int n0;
        for (int i = 0; i < 4; i++) begin
            ax(1, A_OPH, i == 0 ? 32'hFFFF : i == 1 ? 32'h1 : 32'h0);
            op(i == 1 ? 32'h5 : 32'hFFF9, i == 1 ? 32'h10 : 32'h2, OP_DIV_S32 + i);
            ax(1, A_CTRL, OP_ADD);
            n = 0;
            s = 32'h100;
            while (s[8] === 1'b1 && n < 40) begin
                h.go(1'b0, A_STAT, s, rs);
                n++;
            end
            if (s[8] !== 1'b0) abort();
            if (i == 0) n0 = n;
            chk(n, n0);
            ax(0, A_WREG0, q[i]);
            ax(0, A_WREG1, r[i]);
            ax(0, A_CTRL, OP_DIV_S32 + i);
        end
    endtask
    task automatic t_dsp();
        op(32'h0, 32'h0, OP_ACC_CLR);
        op(32'h3, 32'h4, OP_MULT_ACC);
        ax(0, A_ACC_A_L, 32'hC);
        op(32'h4, 32'h5, OP_MULT_SUB);
        ax(0, A_ACC_A_L, 32'hFFFFFFF8);
        ax(0, A_ACC_A_H, 32'hFF);
        op(32'h0, 32'h0, OP_ACC_NEG);
        ax(0, A_ACC_A_L, 32'h8);
        ax(0, A_ACC_B_L, 32'h0);
        ax(1, A_CORE, 32'h1);
        op(32'h3, 32'h4, OP_MULTIPLY);
        ax(0, A_ACC_A_L, 32'h18);
    endtask
    task automatic t_sat();
        ax(1, A_CORE, 32'h28);
        op(32'h5, 32'h2, OP_SQ_DIFF);
        ax(0, A_ACC_A_L, 32'h9);
        op(32'h7FFF, 32'h7FFF, OP_MULTIPLY);
        op(32'h7FFF, 32'h7FFF, OP_MULT_ACC);
        op(32'h7FFF, 32'h7FFF, OP_MULT_ACC);
        ax(0, A_ACC_A_L, 32'h7FFFFFFF);
        ax(0, A_ACC_A_H, 32'h0);
        op(32'h0, 32'h0, 32'hD3);
        ax(0, A_MEMWB, 32'h7FFF);
    endtask
    task automatic t_bus();
        ax(0, A_CORE, 32'h0);
        ax(1, 8'h38, 32'h1, RESP_ERR);
        ax(0, 8'h02, 32'h0, RESP_ERR);
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_bus();
        t_alu();
        t_mul();
        t_div();
        t_dsp();
        t_sat();
        stop_test();
    end
endmodule
